// ### bus_release_consts.svh
// constants for the external bus release arbiter
`ifndef BUS_RELEASE_CONSTS_SVH
`define BUS_RELEASE_CONSTS_SVH

`define ADDR_WIDTH 24
`define DATA_WIDTH 8
`define SYNC_STAGES 2
`define RST_STROBE_N 1'b1
`define RST_GRANT_N 1'b1
`define RST_DRIVE 1'b1
`define RST_CLOCK_OUT 1'b0

`endif

// ### bus_release_pkg.sv
// types for the external bus release arbiter
package bus_release_pkg;

  typedef enum logic [2:0]
  {
    OWN_CPU,
    OWN_DMA,
    EXT_FLOAT,
    EXT_GRANT,
    EXT_RELEASE
  } arb_state_e;

endpackage : bus_release_pkg

// ### sampled_pins_if.sv
// synchronised copies of the pins the external master drives
`timescale 1ns/1ps
`default_nettype none
`include "bus_release_consts.svh"

interface sampled_pins_if;
  logic request_n;
  logic [`ADDR_WIDTH-1:0] addr;
  logic io_strobe_n;
  logic memory_strobe_n;

  modport producer (output request_n, output addr, output io_strobe_n, output memory_strobe_n);
  modport consumer (input request_n, input addr, input io_strobe_n, input memory_strobe_n);
endinterface : sampled_pins_if

`default_nettype wire

// ### pin_sampler.sv
// two-stage synchroniser for the bus request and the external master's pins
`timescale 1ns/1ps
`default_nettype none
`include "bus_release_consts.svh"

module pin_sampler
  import bus_release_pkg::*;
#(
  parameter int ADDR_W = `ADDR_WIDTH
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic bus_request_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic io_strobe_n_in,
  input wire logic memory_strobe_n_in,
  sampled_pins_if.producer sampled
);

  localparam int W = ADDR_W + 3;

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] nxt_stage1;
  logic [W-1:0] nxt_stage2;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_stage1 = {bus_request_n, io_strobe_n_in, memory_strobe_n_in, addr_in};
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stage1_ff <= {3'h7, {ADDR_W{1'b0}}};
      stage2_ff <= {3'h7, {ADDR_W{1'b0}}};
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sampled.request_n = stage2_ff[W-1];
  assign sampled.io_strobe_n = stage2_ff[W-2];
  assign sampled.memory_strobe_n = stage2_ff[W-3];
  assign sampled.addr = stage2_ff[ADDR_W-1:0];

endmodule : pin_sampler

`default_nettype wire

// ### external_bus_release_arbiter.sv
// bus release arbiter between the cpu, internal dma and an external master
`timescale 1ns/1ps
`default_nettype none
`include "bus_release_consts.svh"

// How it works
// [RULE_01] external master holds bus_request_n low for as long as it needs the bus
// [RULE_02] on a sampled low request, float address, data, control and drive grant low
// [RULE_03] while granted, address and strobes are inputs driven by the external master
// [RULE_04] a dma request is served before a pending external request
// [RULE_05] the system clock is driven out on a dedicated pin
// [RULE_06] on request release, drop grant first, then drive the bus again
module external_bus_release_arbiter
  import bus_release_pkg::*;
#(
  parameter int ADDR_W = `ADDR_WIDTH,
  parameter int DATA_W = `DATA_WIDTH
)
(
  input wire logic ref_clk,
  input wire logic srst,
  // internal side
  input wire logic dma_request,
  input wire logic cpu_bus_idle,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [DATA_W-1:0] cpu_data,
  input wire logic cpu_data_drive,
  input wire logic cpu_io_strobe_n,
  input wire logic cpu_memory_strobe_n,
  input wire logic cpu_read_n,
  input wire logic cpu_write_n,
  output logic cpu_hold,
  output logic dma_grant,
  output logic ext_owner,
  output logic [ADDR_W-1:0] ext_addr,
  output logic ext_io_strobe_n,
  output logic ext_memory_strobe_n,
  // pins
  input wire logic bus_request_n,
  output logic bus_grant_n,
  output logic system_clock_out,
  input wire logic [ADDR_W-1:0] addr_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic io_strobe_n_in,
  output logic io_strobe_n_out,
  input wire logic memory_strobe_n_in,
  output logic memory_strobe_n_out,
  output logic read_n_out,
  output logic write_n_out,
  output logic control_oe
);

  sampled_pins_if sampled ();

  pin_sampler #(
    .ADDR_W(ADDR_W)
  ) u_sampler (
    .ref_clk(ref_clk),
    .srst(srst),
    .bus_request_n(bus_request_n),
    .addr_in(addr_in),
    .io_strobe_n_in(io_strobe_n_in),
    .memory_strobe_n_in(memory_strobe_n_in),
    .sampled(sampled)
  );

  function automatic logic device_drives(input arb_state_e s);
    device_drives = (s == OWN_CPU) || (s == OWN_DMA);
  endfunction : device_drives

  // ---------------------------------------------------------------
  // arbitration state
  // ---------------------------------------------------------------
  arb_state_e state_ff;
  arb_state_e nxt_state;
  logic hold_ff;
  logic nxt_hold;
  logic dma_grant_ff;
  logic nxt_dma_grant;
  logic ext_owner_ff;
  logic nxt_ext_owner;
  logic grant_n_ff;
  logic nxt_grant_n;
  logic drive_ff;
  logic nxt_drive;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      OWN_CPU:
      begin
        // [RULE_04] dma ahead of external
        if (dma_request && cpu_bus_idle)
          nxt_state = OWN_DMA;
        // [RULE_02] release on sampled request
        else if (!sampled.request_n && cpu_bus_idle)
          nxt_state = EXT_FLOAT;
      end
      OWN_DMA:
      begin
        if (!dma_request)
          nxt_state = OWN_CPU;
      end
      EXT_FLOAT:
      begin
        nxt_state = EXT_GRANT;
      end
      EXT_GRANT:
      begin
        // [RULE_01] held while request stays low
        if (sampled.request_n)
          nxt_state = EXT_RELEASE;
      end
      EXT_RELEASE:
      begin
        // [RULE_06] grant already high, drive next
        nxt_state = OWN_CPU;
      end
      default:
      begin
        nxt_state = OWN_CPU;
      end
    endcase
    nxt_hold = (nxt_state != OWN_CPU);
    nxt_dma_grant = (nxt_state == OWN_DMA);
    // [RULE_03] master owns pins while granted
    nxt_ext_owner = (nxt_state == EXT_GRANT);
    // [RULE_02] grant low only after float
    nxt_grant_n = (nxt_state != EXT_GRANT);
    // [RULE_06] float until grant is back high
    nxt_drive = device_drives(nxt_state);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_ff <= OWN_CPU;
      hold_ff <= 1'b0;
      dma_grant_ff <= 1'b0;
      ext_owner_ff <= 1'b0;
      grant_n_ff <= `RST_GRANT_N;
      drive_ff <= `RST_DRIVE;
    end
    else
    begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      dma_grant_ff <= nxt_dma_grant;
      ext_owner_ff <= nxt_ext_owner;
      grant_n_ff <= nxt_grant_n;
      drive_ff <= nxt_drive;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers and external view
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addr_out_ff;
  logic [ADDR_W-1:0] nxt_addr_out;
  logic [DATA_W-1:0] data_out_ff;
  logic [DATA_W-1:0] nxt_data_out;
  logic data_oe_ff;
  logic nxt_data_oe;
  logic [3:0] ctrl_ff;
  logic [3:0] nxt_ctrl;
  logic [ADDR_W-1:0] ext_addr_ff;
  logic [ADDR_W-1:0] nxt_ext_addr;
  logic [1:0] ext_strobe_ff;
  logic [1:0] nxt_ext_strobe;
  logic clock_out_ff;
  logic nxt_clock_out;

  always_comb
  begin
    nxt_addr_out = cpu_addr;
    nxt_data_out = cpu_data;
    nxt_data_oe = nxt_drive && cpu_data_drive;
    nxt_ctrl = {cpu_io_strobe_n, cpu_memory_strobe_n, cpu_read_n, cpu_write_n};
    if (!nxt_drive)
      nxt_ctrl = {4{`RST_STROBE_N}};
    // [RULE_03] capture master address and strobes
    nxt_ext_addr = ext_addr_ff;
    nxt_ext_strobe = {`RST_STROBE_N, `RST_STROBE_N};
    if (state_ff == EXT_GRANT)
    begin
      nxt_ext_addr = sampled.addr;
      nxt_ext_strobe = {sampled.io_strobe_n, sampled.memory_strobe_n};
    end
    // [RULE_05] system clock out, ref_clk / 2
    nxt_clock_out = !clock_out_ff;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      addr_out_ff <= {ADDR_W{1'b0}};
      data_out_ff <= {DATA_W{1'b0}};
      data_oe_ff <= 1'b0;
      ctrl_ff <= {4{`RST_STROBE_N}};
      ext_addr_ff <= {ADDR_W{1'b0}};
      ext_strobe_ff <= {`RST_STROBE_N, `RST_STROBE_N};
      clock_out_ff <= `RST_CLOCK_OUT;
    end
    else
    begin
      addr_out_ff <= nxt_addr_out;
      data_out_ff <= nxt_data_out;
      data_oe_ff <= nxt_data_oe;
      ctrl_ff <= nxt_ctrl;
      ext_addr_ff <= nxt_ext_addr;
      ext_strobe_ff <= nxt_ext_strobe;
      clock_out_ff <= nxt_clock_out;
    end
  end

  assign cpu_hold = hold_ff;
  assign dma_grant = dma_grant_ff;
  assign ext_owner = ext_owner_ff;
  assign bus_grant_n = grant_n_ff;
  assign addr_out = addr_out_ff;
  assign addr_oe = drive_ff;
  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign io_strobe_n_out = ctrl_ff[3];
  assign memory_strobe_n_out = ctrl_ff[2];
  assign read_n_out = ctrl_ff[1];
  assign write_n_out = ctrl_ff[0];
  assign control_oe = drive_ff;
  assign ext_addr = ext_addr_ff;
  assign ext_io_strobe_n = ext_strobe_ff[1];
  assign ext_memory_strobe_n = ext_strobe_ff[0];
  assign system_clock_out = clock_out_ff;

endmodule : external_bus_release_arbiter

`default_nettype wire

// ### bus_arb_checker.sv
// assertions on the bus release arbiter ports
`timescale 1ns/1ps
`default_nettype none
module bus_arb_checker
#(
  parameter int ADDR_W = 24
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic dma_request,
  input wire logic cpu_bus_idle,
  input wire logic cpu_hold,
  input wire logic dma_grant,
  input wire logic ext_owner,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic system_clock_out,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic control_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence floated;
    !addr_oe && !control_oe && !data_oe;
  endsequence
  sequence driven;
    addr_oe && control_oe;
  endsequence
  grant_float_a: assert property (!bus_grant_n |-> floated ##0 cpu_hold)
    else $error("bus driven during grant");
  ask_grant_a: assert property ((!bus_request_n && cpu_bus_idle && !dma_request && !dma_grant)[*8] |-> !bus_grant_n)
    else $error("request not granted");
  idle_gate_a: assert property (!cpu_bus_idle && !cpu_hold |=> !cpu_hold)
    else $error("bus taken while cpu busy");
  owner_flag_a: assert property (ext_owner == !bus_grant_n)
    else $error("owner flag differs from grant");
  ext_addr_a: assert property ((!bus_grant_n)[*5] |-> ext_addr == $past(addr_in, 3))
    else $error("master address not taken");
  dma_first_a: assert property (dma_request && cpu_bus_idle && !cpu_hold |=> dma_grant ##0 bus_grant_n)
    else $error("dma not served first");
  dma_keep_a: assert property (dma_grant |-> driven and (cpu_hold && bus_grant_n))
    else $error("bad bus state under dma");
  dma_end_a: assert property ($fell(dma_request) && dma_grant |=> !dma_grant)
    else $error("dma grant kept");
  clock_out_a: assert property (!$past(srst) |-> system_clock_out != $past(system_clock_out))
    else $error("clock out not toggling");
  release_a: assert property ($rose(bus_grant_n) |-> floated ##1 driven)
    else $error("bad release order");
endmodule : bus_arb_checker
bind external_bus_release_arbiter bus_arb_checker #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// ### ext_master.sv
// model of the external bus master and the shared pins
`timescale 1ns/1ps
`default_nettype none
module ext_master
(
  input wire logic ref_clk,
  input wire logic want,
  input wire logic [23:0] addr_val,
  input wire logic bus_grant_n,
  input wire logic addr_oe,
  input wire logic [23:0] addr_out,
  input wire logic control_oe,
  input wire logic io_out_n,
  input wire logic mem_out_n,
  output logic bus_request_n,
  output logic [23:0] addr_pin,
  output logic io_pin_n,
  output logic mem_pin_n
);
  initial bus_request_n = 1'b1;
  always @(posedge ref_clk) bus_request_n <= !want;
  assign addr_pin = !bus_grant_n ? addr_val : (addr_oe ? addr_out : ~addr_out);
  assign io_pin_n = !bus_grant_n ? 1'b0 : (control_oe ? io_out_n : ~io_out_n);
  assign mem_pin_n = !bus_grant_n ? 1'b1 : (control_oe ? mem_out_n : ~mem_out_n);
endmodule : ext_master
`default_nettype wire

// ### external_bus_release_arbiter_tb.sv
// self-checking bench for the bus release arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("Error %0t %h %h", $time, a, b); end end
module external_bus_release_arbiter_tb import bus_release_pkg::*;;
  logic ref_clk = 1'b0, srst = 1'b1, dma_request = 1'b0, cpu_bus_idle = 1'b1, want = 1'b0;
  logic drv = 1'b0, cio = 1'b1, cmem = 1'b1, crd = 1'b1, cwr = 1'b1, pdrv, psrst = 1'b1;
  logic [3:0] pctrl;
  logic [36:0] pexp;
  logic [23:0] cpu_addr = 24'h0, addr_val, addr_in, addr_out, ext_addr, paddr;
  logic [7:0] cpu_data = 8'h00, data_out, pdata;
  logic req_n, grant_n, io_n, mem_n, hold, dgrant, owner, eio, emem, ck_out, aoe, doe, io_o, mem_o, rd_o, wr_o, coe;
  logic [3:0] exp_q[$];
  logic [3:0] want_v;
  logic [1:0] last = 2'h2;
  int err_count = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  external_bus_release_arbiter dut (.ref_clk(ref_clk), .srst(srst), .dma_request(dma_request),
    .cpu_bus_idle(cpu_bus_idle), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_data_drive(drv),
    .cpu_io_strobe_n(cio), .cpu_memory_strobe_n(cmem), .cpu_read_n(crd), .cpu_write_n(cwr), .cpu_hold(hold),
    .dma_grant(dgrant), .ext_owner(owner), .ext_addr(ext_addr), .ext_io_strobe_n(eio), .ext_memory_strobe_n(emem),
    .bus_request_n(req_n), .bus_grant_n(grant_n), .system_clock_out(ck_out), .addr_in(addr_in),
    .addr_out(addr_out), .addr_oe(aoe), .data_out(data_out), .data_oe(doe), .io_strobe_n_in(io_n),
    .io_strobe_n_out(io_o), .memory_strobe_n_in(mem_n), .memory_strobe_n_out(mem_o), .read_n_out(rd_o),
    .write_n_out(wr_o), .control_oe(coe));
  ext_master partner (.ref_clk(ref_clk), .want(want), .addr_val(addr_val), .bus_grant_n(grant_n), .addr_oe(aoe),
    .addr_out(addr_out), .control_oe(coe), .io_out_n(io_o), .mem_out_n(mem_o), .bus_request_n(req_n),
    .addr_pin(addr_in), .io_pin_n(io_n), .mem_pin_n(mem_n));
  always @(posedge ref_clk)
  begin
    cpu_addr <= 24'($urandom);
    cpu_data <= 8'($urandom);
    {drv, cio, cmem, crd, cwr} <= 5'($urandom);
  end
  // ownership changes popped from the queue
  always @(negedge ref_clk)
  begin
    if (!srst && {grant_n, dgrant} !== last)
    begin
      want_v = (exp_q.size() != 0) ? exp_q.pop_front() : 4'hX;
      `CHK({grant_n, dgrant, aoe, coe}, want_v)
    end
    // floated pins read idle strobes and no data drive
    pexp = aoe ? {paddr, pdata, pctrl, pdrv} : {paddr, pdata, 4'hF, 1'b0};
    if (!srst && !psrst)
      `CHK({addr_out, data_out, io_o, mem_o, rd_o, wr_o, doe}, pexp)
    last = {grant_n, dgrant};
    {psrst, pdrv, pctrl, paddr, pdata} = {srst, drv, cio, cmem, crd, cwr, cpu_addr, cpu_data};
  end
  task close_out;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #5us;
    err_count++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h2588));
    addr_val = 24'($urandom);
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK({grant_n, aoe, coe, doe, ck_out, hold, dgrant, owner}, 8'hE0)
    @(posedge ref_clk);
    srst <= 1'b0;
    cpu_bus_idle <= 1'b0;
    want <= 1'b1;
    repeat (10) @(posedge ref_clk);
    exp_q.push_back(4'h0);
    cpu_bus_idle <= 1'b1;
    wait (exp_q.size() == 0);
    repeat (6) @(negedge ref_clk);
    `CHK({ext_addr, eio, emem}, {addr_val, 2'h1})
    exp_q = {4'h8, 4'hF};
    @(posedge ref_clk);
    dma_request <= 1'b1;
    repeat (4) @(posedge ref_clk);
    want <= 1'b0;
    wait (exp_q.size() == 0);
    exp_q.push_back(4'hB);
    @(posedge ref_clk);
    dma_request <= 1'b0;
    wait (exp_q.size() == 0);
    exp_q = {4'hF, 4'hB, 4'h0, 4'h8};
    repeat (3) @(posedge ref_clk);
    want <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dma_request <= 1'b1;
    repeat (8) @(posedge ref_clk);
    dma_request <= 1'b0;
    repeat (12) @(posedge ref_clk);
    want <= 1'b0;
    wait (exp_q.size() == 0);
    repeat (5) @(posedge ref_clk);
    close_out();
  end
endmodule : external_bus_release_arbiter_tb
`default_nettype wire
